/* File: rtl/fpm_device.sv */
// Memory select, sector protection and flash command control end.
// Behaviour
// - sector locks loaded only from programmer port
// - MCU reads locks, can never change them
// - program or erase of locked sector dropped
// - verify of locked sector is plain read
// - primary lock status bits seven to zero
// - secondary locks bits 3-0, security bit 7
// - reset command alone or after unlock pair
// - MCU issues reset after status, ID, error
// - error cleared to read within 25 us
// - reset ignored during program or bulk erase
// - reset aborts sector erase within 25 us
// - reset pin aborts any cycle, recovers
// - reset pulse held at least 25 us
// - SRAM enabled only while its select high
// - secondary sector beats overlapping primary sector
// - SRAM, I/O, peripheral beat any flash
// - decode selects never overlap illegally
// - map loads boot value, MCU rewrites anytime
// - map bits gate fetch and data reads
// - value 0Ch gives separate program/data spaces
// - bits 2 and 4 combine primary flash
// - bad erase sequence byte returns to read
module fpm_device #(
	parameter logic [7:0] MAP_INIT = fpm_pkg::MAP_BOOT,
	parameter int         RECOVER  = fpm_pkg::RECOVER_CYC
) (
	// Clock and reset.
	input  wire logic        ref_clk,
	input  wire logic        reset_n,
	// MCU bus.
	fpm_if.dev               bus,
	// Decode array selects.
	input  wire logic [7:0]  primary_sector_selects,
	input  wire logic [3:0]  secondary_sector_selects,
	input  wire logic        static_ram_select,
	input  wire logic        control_register_window,
	input  wire logic        peripheral_io_window,
	// Programmer port for locks.
	input  wire logic        lock_load,
	input  wire logic [7:0]  lock_primary_in,
	input  wire logic [3:0]  lock_secondary_in,
	input  wire logic        security_in,
	// Reset pin from outside.
	input  wire logic        flash_reset_pin,
	// Flash array engine.
	input  wire logic [7:0]  mem_rdata,
	input  wire logic        array_done,
	input  wire logic        array_error,
	output logic             array_program,
	output logic             array_erase,
	output logic [11:0]      array_sector_mask,
	output logic [15:0]      array_addr,
	output logic [7:0]       array_data,
	output logic             array_abort,
	output logic             error_flag_bit,
	output logic             flash_ready,
	// Memory enables.
	output logic             sram_enable,
	output logic [7:0]       primary_enable,
	output logic [3:0]       secondary_enable,
	output logic             io_enable,
	output logic             pio_enable
);
	fpm_pkg::fpm_fl_state_t state_r;
	fpm_pkg::fpm_fl_state_t state_nxt;
	logic [7:0]  pri_lock_r;
	logic [3:0]  sec_lock_r;
	logic        security_r;
	logic [7:0]  map_r;
	logic [1:0]  pin_sync_r;
	logic        pin_prev_r;
	logic [9:0]  recov_cnt_r;
	logic [11:0] target;
	logic [11:0] unlocked;
	logic [11:0] all_locks;
	logic        low_hit;
	logic        flash_hit;
	logic        win_hit;
	logic        fl_wr;
	logic        pin_rise;
	logic        go_prog;
	logic        go_erase;
	logic [11:0] go_mask;
	logic        abort_now;
	logic        recover_go;

	// Lock bits come only from the programmer port, never from the bus.
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			pri_lock_r <= 8'h00;
			sec_lock_r <= 4'h0;
			security_r <= 1'b0;
		end else if (lock_load) begin
			pri_lock_r <= lock_primary_in;
			sec_lock_r <= lock_secondary_in;
			security_r <= security_in;
		end
	end

	assign win_hit = control_register_window & ~static_ram_select;

	// The map register is the only bus-writable register in the window.
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			map_r <= MAP_INIT;
		end else if (bus.wr_stb && win_hit &&
				bus.addr[7:0] == fpm_pkg::OFS_MEM_MAP) begin
			map_r <= bus.wdata & fpm_pkg::MAP_USED;
		end
	end

	// Priority: SRAM, I/O and peripheral window sit above all flash.
	assign low_hit = static_ram_select | control_register_window |
		(peripheral_io_window & map_r[fpm_pkg::MAP_PERIPHERAL_WINDOW_ENABLE]);

	always_comb begin
		sram_enable      = 1'b0;
		io_enable        = 1'b0;
		pio_enable       = 1'b0;
		primary_enable   = 8'h00;
		secondary_enable = 4'h0;
		if (static_ram_select) begin
			sram_enable = bus.wr_stb | bus.rd_stb |
				(bus.program_fetch_strobe &
				map_r[fpm_pkg::MAP_RAM_FETCH]);
		end else if (control_register_window) begin
			io_enable = 1'b1;
		end else if (peripheral_io_window && map_r[fpm_pkg::MAP_PERIPHERAL_WINDOW_ENABLE]) begin
			pio_enable = 1'b1;
		end else if (|secondary_sector_selects) begin
			if (bus.wr_stb ||
					(bus.rd_stb && map_r[fpm_pkg::MAP_SEC_DATA]) ||
					(bus.program_fetch_strobe &&
					map_r[fpm_pkg::MAP_SEC_FETCH])) begin
				secondary_enable = secondary_sector_selects;
			end
		end else if (bus.wr_stb ||
				(bus.rd_stb && map_r[fpm_pkg::MAP_PRI_DATA]) ||
				(bus.program_fetch_strobe &&
				map_r[fpm_pkg::MAP_PRI_FETCH])) begin
			primary_enable = primary_sector_selects;
		end
	end

	assign target = low_hit ? 12'h000 : ((|secondary_sector_selects) ?
		{secondary_sector_selects, 8'h00} :
		{4'h0, primary_sector_selects});
	assign all_locks = {sec_lock_r, pri_lock_r};
	assign unlocked  = ~all_locks;
	assign flash_hit = |target;
	assign fl_wr     = bus.wr_stb & flash_hit;

	// Reset pin is synchronised; only the second stage feeds logic.
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			pin_sync_r <= 2'b00;
			pin_prev_r <= 1'b0;
		end else begin
			pin_sync_r <= {pin_sync_r[0], flash_reset_pin};
			pin_prev_r <= pin_sync_r[1];
		end
	end
	assign pin_rise = pin_sync_r[1] & ~pin_prev_r;

	// Flash command sequencer.
	always_comb begin
		state_nxt  = state_r;
		go_prog    = 1'b0;
		go_erase   = 1'b0;
		go_mask    = 12'h000;
		abort_now  = 1'b0;
		recover_go = 1'b0;
		unique case (state_r)
			fpm_pkg::FL_READ: begin
				if (fl_wr && bus.wdata == fpm_pkg::CMD_RESET) begin
					recover_go = error_flag_bit;
				end else if (fl_wr && bus.wdata == fpm_pkg::UNLOCK_DAT1 &&
						bus.addr[11:0] == fpm_pkg::UNLOCK_ADR1) begin
					state_nxt = fpm_pkg::FL_UNL1;
				end
			end
			fpm_pkg::FL_UNL1: begin
				if (fl_wr) begin
					state_nxt = (bus.wdata == fpm_pkg::UNLOCK_DAT2 &&
						bus.addr[11:0] == fpm_pkg::UNLOCK_ADR2) ?
						fpm_pkg::FL_UNL2 : fpm_pkg::FL_READ;
				end
			end
			fpm_pkg::FL_UNL2: begin
				if (fl_wr) begin
					if (bus.wdata == fpm_pkg::CMD_PROGRAM) begin
						state_nxt = fpm_pkg::FL_PROG;
					end else if (bus.wdata == fpm_pkg::CMD_ERASE) begin
						state_nxt = fpm_pkg::FL_EUNL0;
					end else begin
						state_nxt  = fpm_pkg::FL_READ;
						recover_go = error_flag_bit &&
							bus.wdata == fpm_pkg::CMD_RESET;
					end
				end
			end
			fpm_pkg::FL_PROG: begin
				if (fl_wr) begin
					go_mask = target & unlocked;
					go_prog = |go_mask;
					state_nxt = go_prog ? fpm_pkg::FL_BUSY_P :
						fpm_pkg::FL_READ;
				end
			end
			fpm_pkg::FL_EUNL0: begin
				if (fl_wr) begin
					state_nxt = (bus.wdata == fpm_pkg::UNLOCK_DAT1 &&
						bus.addr[11:0] == fpm_pkg::UNLOCK_ADR1) ?
						fpm_pkg::FL_EUNL1 : fpm_pkg::FL_READ;
				end
			end
			fpm_pkg::FL_EUNL1: begin
				if (fl_wr) begin
					state_nxt = (bus.wdata == fpm_pkg::UNLOCK_DAT2 &&
						bus.addr[11:0] == fpm_pkg::UNLOCK_ADR2) ?
						fpm_pkg::FL_EUNL2 : fpm_pkg::FL_READ;
				end
			end
			fpm_pkg::FL_EUNL2: begin
				if (fl_wr) begin
					state_nxt = fpm_pkg::FL_READ;
					if (bus.wdata == fpm_pkg::CMD_BULK) begin
						go_mask = unlocked;
						go_erase = |go_mask;
						if (go_erase) state_nxt = fpm_pkg::FL_BUSY_B;
					end else if (bus.wdata == fpm_pkg::CMD_SECTOR) begin
						go_mask = target & unlocked;
						go_erase = |go_mask;
						if (go_erase) state_nxt = fpm_pkg::FL_BUSY_S;
					end
				end
			end
			fpm_pkg::FL_BUSY_P, fpm_pkg::FL_BUSY_B: begin
				// Reset commands are not looked at here.
				if (array_done) state_nxt = fpm_pkg::FL_READ;
			end
			fpm_pkg::FL_BUSY_S: begin
				if (array_done) begin
					state_nxt = fpm_pkg::FL_READ;
				end else if (fl_wr && bus.wdata == fpm_pkg::CMD_RESET) begin
					abort_now  = 1'b1;
					recover_go = 1'b1;
				end
			end
			fpm_pkg::FL_RECOV: begin
				if (recov_cnt_r == 10'(RECOVER - 1)) begin
					state_nxt = fpm_pkg::FL_READ;
				end
			end
			default: state_nxt = fpm_pkg::FL_READ;
		endcase
		if (recover_go) state_nxt = fpm_pkg::FL_RECOV;
		if (pin_rise) begin
			// Abort is issued for any cycle; busy ones need recovery time.
			go_prog   = 1'b0;
			go_erase  = 1'b0;
			abort_now = 1'b1;
			state_nxt = (state_r == fpm_pkg::FL_BUSY_P ||
				state_r == fpm_pkg::FL_BUSY_B ||
				state_r == fpm_pkg::FL_BUSY_S ||
				state_r == fpm_pkg::FL_RECOV) ?
				fpm_pkg::FL_RECOV : fpm_pkg::FL_READ;
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) state_r <= fpm_pkg::FL_READ;
		else state_r <= state_nxt;
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) recov_cnt_r <= 10'h000;
		else if (state_nxt == fpm_pkg::FL_RECOV && state_r != state_nxt)
			recov_cnt_r <= 10'h000;
		else if (state_r == fpm_pkg::FL_RECOV)
			recov_cnt_r <= recov_cnt_r + 10'h001;
	end

	// Error flag: set by the array, cleared when recovery returns to read mode.
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) error_flag_bit <= 1'b0;
		else if (array_error) error_flag_bit <= 1'b1;
		else if (state_r == fpm_pkg::FL_RECOV &&
				state_nxt == fpm_pkg::FL_READ)
			error_flag_bit <= 1'b0;
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			array_program     <= 1'b0;
			array_erase       <= 1'b0;
			array_abort       <= 1'b0;
			array_sector_mask <= 12'h000;
			array_addr        <= 16'h0000;
			array_data        <= 8'h00;
		end else begin
			array_program <= go_prog;
			array_erase   <= go_erase;
			array_abort   <= abort_now;
			if (go_prog || go_erase) begin
				array_sector_mask <= go_mask;
				array_addr        <= bus.addr;
				array_data        <= bus.wdata;
			end
		end
	end

	assign flash_ready = (state_r != fpm_pkg::FL_BUSY_P) &&
		(state_r != fpm_pkg::FL_BUSY_B) &&
		(state_r != fpm_pkg::FL_BUSY_S) &&
		(state_r != fpm_pkg::FL_RECOV);

	// Read data is latched on the strobe edge; locked sectors read normally.
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			bus.rdata <= 8'h00;
		end else if (bus.rd_stb || bus.program_fetch_strobe) begin
			if (win_hit && bus.rd_stb) begin
				unique case (bus.addr[7:0])
					fpm_pkg::OFS_PRI_LOCK: bus.rdata <= pri_lock_r;
					fpm_pkg::OFS_SEC_LOCK: bus.rdata <=
						{security_r, 3'b000, sec_lock_r};
					fpm_pkg::OFS_MEM_MAP: bus.rdata <= map_r;
					default: bus.rdata <= 8'h00;
				endcase
			end else begin
				bus.rdata <= mem_rdata;
			end
		end
	end
	// all_locks is kept for readability of the lock mask.
endmodule // fpm_device

/* File: rtl/fpm_pkg.sv */
// Shared constants and types for the controller and memory select ends.
package fpm_pkg;
	// Control register window offsets (low address byte).
	localparam logic [7:0]  OFS_PRI_LOCK  = 8'hC0;
	localparam logic [7:0]  OFS_SEC_LOCK  = 8'hC2;
	localparam logic [7:0]  OFS_MEM_MAP   = 8'hC4;
	// Memory space map field positions.
	localparam int          MAP_PERIPHERAL_WINDOW_ENABLE    = 7;
	localparam int          MAP_PRI_DATA  = 4;
	localparam int          MAP_SEC_DATA  = 3;
	localparam int          MAP_PRI_FETCH = 2;
	localparam int          MAP_SEC_FETCH = 1;
	localparam int          MAP_RAM_FETCH = 0;
	localparam logic [7:0]  MAP_BOOT      = 8'h0C;
	localparam logic [7:0]  MAP_USED      = 8'h9F;
	// Secondary lock register layout.
	localparam int          SEC_SECURITY  = 7;
	// Flash command sequence codes.
	localparam logic [11:0] UNLOCK_ADR1   = 12'h555;
	localparam logic [11:0] UNLOCK_ADR2   = 12'hAAA;
	localparam logic [7:0]  UNLOCK_DAT1   = 8'hAA;
	localparam logic [7:0]  UNLOCK_DAT2   = 8'h55;
	localparam logic [7:0]  CMD_PROGRAM   = 8'hA0;
	localparam logic [7:0]  CMD_ERASE     = 8'h80;
	localparam logic [7:0]  CMD_BULK      = 8'h10;
	localparam logic [7:0]  CMD_SECTOR    = 8'h30;
	localparam logic [7:0]  CMD_RESET     = 8'hF0;
	// Return-to-read timing.
	localparam int          CLK_PERIOD_NS = 40;
	localparam int          RECOVER_NS    = 25000;
	localparam int          RECOVER_CYC   = RECOVER_NS / CLK_PERIOD_NS;
	// Host register map (byte addresses on AHB-Lite).
	localparam logic [7:0]  H_OFS_ADDR    = 8'h00;
	localparam logic [7:0]  H_OFS_CMD     = 8'h04;
	localparam logic [7:0]  H_OFS_STAT    = 8'h08;
	localparam logic [1:0]  OP_WRITE      = 2'h1;
	localparam logic [1:0]  OP_READ       = 2'h2;
	localparam logic [1:0]  OP_FETCH      = 2'h3;

	typedef enum logic [3:0] {
		FL_READ   = 4'b0000,
		FL_UNL1   = 4'b0001,
		FL_UNL2   = 4'b0010,
		FL_PROG   = 4'b0011,
		FL_EUNL0  = 4'b0100,
		FL_EUNL1  = 4'b0101,
		FL_EUNL2  = 4'b0110,
		FL_BUSY_P = 4'b0111,
		FL_BUSY_B = 4'b1000,
		FL_BUSY_S = 4'b1001,
		FL_RECOV  = 4'b1010
	} fpm_fl_state_t;

	typedef enum logic [1:0] {
		HS_IDLE   = 2'b00,
		HS_STROBE = 2'b01,
		HS_CAPT   = 2'b10
	} fpm_host_state_t;
endpackage

/* File: rtl/fpm_if.sv */
// MCU bus between the controller end and the memory select end.
interface fpm_if;
	logic [15:0] addr;
	logic [7:0]  wdata;
	logic        wr_stb;
	logic        rd_stb;
	logic        program_fetch_strobe;
	logic [7:0]  rdata;

	modport mcu (output addr, wdata, wr_stb, rd_stb, program_fetch_strobe,
		input rdata);
	modport dev (input addr, wdata, wr_stb, rd_stb, program_fetch_strobe,
		output rdata);
endinterface

/* File: rtl/fpm_host.sv */
// Controller end: AHB-Lite registers that drive single MCU bus cycles.
module fpm_host (
	// Clock and reset.
	input  wire logic        ref_clk,
	input  wire logic        reset_n,
	// AHB-Lite slave.
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	// MCU bus.
	fpm_if.mcu               bus
);
	fpm_pkg::fpm_host_state_t st_r;
	logic [15:0] addr_r;
	logic [7:0]  wdata_r;
	logic [7:0]  rdata_r;
	logic [1:0]  op_r;
	logic        ph_wr_r;
	logic        ph_rd_r;
	logic [7:0]  ph_ofs_r;
	logic        kick;

	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	// Address phase capture; the data phase follows on the next cycle.
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			ph_wr_r  <= 1'b0;
			ph_rd_r  <= 1'b0;
			ph_ofs_r <= 8'h00;
		end else if (hready) begin
			ph_wr_r  <= hsel & htrans[1] & hwrite;
			ph_rd_r  <= hsel & htrans[1] & ~hwrite;
			ph_ofs_r <= haddr[7:0];
		end
	end

	assign kick = ph_wr_r && ph_ofs_r == fpm_pkg::H_OFS_CMD &&
		hwdata[1:0] != 2'b00 && st_r == fpm_pkg::HS_IDLE;

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			addr_r  <= 16'h0000;
			wdata_r <= 8'h00;
		end else if (ph_wr_r && ph_ofs_r == fpm_pkg::H_OFS_ADDR) begin
			addr_r  <= hwdata[15:0];
			wdata_r <= hwdata[23:16];
		end
	end

	// One strobe cycle, then one cycle to take the read data.
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			st_r <= fpm_pkg::HS_IDLE;
			op_r <= 2'b00;
		end else begin
			unique case (st_r)
				fpm_pkg::HS_IDLE: if (kick) begin
					st_r <= fpm_pkg::HS_STROBE;
					op_r <= hwdata[1:0];
				end
				fpm_pkg::HS_STROBE: st_r <= (op_r == fpm_pkg::OP_WRITE) ?
					fpm_pkg::HS_IDLE : fpm_pkg::HS_CAPT;
				fpm_pkg::HS_CAPT: st_r <= fpm_pkg::HS_IDLE;
				default: st_r <= fpm_pkg::HS_IDLE;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) rdata_r <= 8'h00;
		else if (st_r == fpm_pkg::HS_CAPT) rdata_r <= bus.rdata;
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			bus.wr_stb               <= 1'b0;
			bus.rd_stb               <= 1'b0;
			bus.program_fetch_strobe <= 1'b0;
			bus.addr                 <= 16'h0000;
			bus.wdata                <= 8'h00;
		end else begin
			bus.wr_stb <= kick && hwdata[1:0] == fpm_pkg::OP_WRITE;
			bus.rd_stb <= kick && hwdata[1:0] == fpm_pkg::OP_READ;
			bus.program_fetch_strobe <= kick &&
				hwdata[1:0] == fpm_pkg::OP_FETCH;
			if (kick) begin
				bus.addr  <= addr_r;
				bus.wdata <= wdata_r;
			end
		end
	end

	always_comb begin
		hrdata = 32'h0000_0000;
		if (ph_rd_r) begin
			unique case (ph_ofs_r)
				fpm_pkg::H_OFS_ADDR: hrdata = {8'h00, wdata_r, addr_r};
				fpm_pkg::H_OFS_CMD:  hrdata = {30'h0000_0000, op_r};
				fpm_pkg::H_OFS_STAT: hrdata = {16'h0000, rdata_r, 7'h00,
					st_r != fpm_pkg::HS_IDLE};
				default: hrdata = 32'h0000_0000;
			endcase
		end
	end
endmodule // fpm_host

/* File: test/fpm_properties.sv */
// Bus-level properties for the joined host and device ends.
module fpm_properties #(
	parameter logic [7:0] MAP_INIT = 8'h0C,
	parameter int         RECOVER  = 625
) (
	// Clock and reset.
	input wire logic        ref_clk,
	input wire logic        reset_n,
	// MCU bus.
	input wire logic [15:0] addr,
	input wire logic [7:0]  wdata,
	input wire logic        wr_stb,
	input wire logic        rd_stb,
	input wire logic [7:0]  rdata,
	// Decode and lock load.
	input wire logic        static_ram_select,
	input wire logic        control_register_window,
	input wire logic        lock_load,
	input wire logic [7:0]  lock_primary_in,
	input wire logic [3:0]  lock_secondary_in,
	input wire logic        security_in,
	// Device outputs.
	input wire logic        array_program,
	input wire logic        array_erase,
	input wire logic        array_abort,
	input wire logic [11:0] array_sector_mask,
	input wire logic        flash_ready,
	input wire logic        sram_enable,
	input wire logic [7:0]  primary_enable,
	input wire logic [3:0]  secondary_enable,
	input wire logic        io_enable,
	input wire logic        pio_enable
);
	localparam int REC_MAX = RECOVER + 8;
	logic [12:0] lock_r;
	logic [7:0]  map_r;
	logic        win;

	assign win = control_register_window & ~static_ram_select;

	// Lock shadow only follows the programmer port, never bus writes; the map shadow follows bus writes.
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n)
			lock_r <= '0;
		else if (lock_load)
			lock_r <= {security_in, lock_secondary_in, lock_primary_in};
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n)
			map_r <= MAP_INIT;
		else if (wr_stb && win && addr[7:0] == fpm_pkg::OFS_MEM_MAP)
			map_r <= wdata & fpm_pkg::MAP_USED;
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);

	a_sram_needs_select: assert property (
		sram_enable |-> static_ram_select)
		else $error("sram enabled without its select");
	a_secondary_first: assert property (
		|secondary_enable |-> primary_enable == 8'h00)
		else $error("primary sector enabled beside secondary");
	a_ram_io_first: assert property (
		(sram_enable || io_enable || pio_enable)
		|-> {primary_enable, secondary_enable} == 12'h000)
		else $error("flash enabled beside sram or io");
	a_pri_lock_read: assert property (
		rd_stb && win && addr[7:0] == fpm_pkg::OFS_PRI_LOCK
		|=> rdata == lock_r[7:0])
		else $error("primary lock readback wrong");
	a_sec_lock_read: assert property (
		rd_stb && win && addr[7:0] == fpm_pkg::OFS_SEC_LOCK
		|=> rdata == {lock_r[12], 3'b000, lock_r[11:8]})
		else $error("secondary lock readback wrong");
	a_map_readback: assert property (
		rd_stb && win && addr[7:0] == fpm_pkg::OFS_MEM_MAP
		|=> rdata == map_r)
		else $error("memory space map readback wrong");
	a_locked_untouched: assert property (
		(array_program || array_erase)
		|-> (array_sector_mask & lock_r[11:0]) == 12'h000)
		else $error("array operation on a locked sector");
	a_abort_recovers: assert property (
		array_abort |-> ##[1:REC_MAX] flash_ready)
		else $error("flash not back to read after abort");

	c_abort: cover property (array_abort);
	c_program: cover property (array_program);
	c_erase: cover property (array_erase);
	c_sram: cover property (sram_enable);
endmodule // fpm_properties

/* File: test/fpm_tb.sv */
// Self-checking bench for the host and device ends on one MCU bus.
`define CHK(g, e) \
	begin \
		compares++; \
		if ((g) !== (e)) begin \
			error_cnt++; \
			$display("ERROR %0t: got %0h expected %0h", $time, g, e); \
		end \
	end

module fpm_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int REC = 8;
	logic        ref_clk, reset_n, hsel, hwrite, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0]  htrans;
	logic        static_ram_select, control_register_window;
	logic        peripheral_io_window, lock_load, security_in;
	logic        flash_reset_pin, array_done, array_error;
	logic [7:0]  primary_sector_selects, lock_primary_in, mem_rdata;
	logic [3:0]  secondary_sector_selects, lock_secondary_in;
	logic        array_program, array_erase, array_abort, error_flag_bit;
	logic        flash_ready, sram_enable, io_enable, pio_enable;
	logic [11:0] array_sector_mask;
	logic [7:0]  primary_enable;
	logic [3:0]  secondary_enable;
	int          error_cnt, compares, seed, cyc, n_prog, n_erase, n_abort;

	fpm_if bus_if ();
	fpm_host i_fpm_host (.ref_clk, .reset_n, .hsel, .haddr, .htrans,
		.hwrite, .hsize(3'b010), .hwdata, .hready(hreadyout), .hreadyout,
		.hresp, .hrdata, .bus(bus_if));
	fpm_device #(.RECOVER(REC)) i_fpm_device (.ref_clk, .reset_n,
		.bus(bus_if), .primary_sector_selects, .secondary_sector_selects,
		.static_ram_select, .control_register_window, .peripheral_io_window,
		.lock_load, .lock_primary_in, .lock_secondary_in, .security_in,
		.flash_reset_pin, .mem_rdata, .array_done, .array_error,
		.array_program, .array_erase, .array_sector_mask, .array_addr(),
		.array_data(), .array_abort, .error_flag_bit, .flash_ready,
		.sram_enable, .primary_enable, .secondary_enable, .io_enable,
		.pio_enable);
	fpm_properties #(.RECOVER(REC)) i_fpm_properties (.ref_clk, .reset_n,
		.addr(bus_if.addr), .wdata(bus_if.wdata), .wr_stb(bus_if.wr_stb),
		.rd_stb(bus_if.rd_stb), .rdata(bus_if.rdata), .static_ram_select,
		.control_register_window, .lock_load, .lock_primary_in,
		.lock_secondary_in, .security_in, .array_program, .array_erase,
		.array_abort, .array_sector_mask, .flash_ready, .sram_enable,
		.primary_enable, .secondary_enable, .io_enable, .pio_enable);

	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end

	task automatic close_out();
		$display("compares %0d errors %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Pulse counters sample before the edge, so a one-cycle pulse counts once.
	always @(posedge ref_clk) begin
		cyc++;
		if (array_program === 1'b1) n_prog++;
		if (array_erase === 1'b1) n_erase++;
		if (array_abort === 1'b1) n_abort++;
		if (cyc == 20000) begin
			error_cnt++;
			close_out();
		end
	end

	task automatic ahb(input logic w, input logic [31:0] a,
			input logic [31:0] d, output logic [31:0] r);
		@(posedge ref_clk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= a;
		hwrite <= w;
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask

	// One MCU bus cycle: load address and data, kick, poll busy.
	task automatic op(input logic [1:0] o, input logic [15:0] a,
			input logic [7:0] d, output logic [7:0] q);
		logic [31:0] r;
		int k;
		ahb(1'b1, {24'h0, fpm_pkg::H_OFS_ADDR}, {8'h00, d, a}, r);
		ahb(1'b1, {24'h0, fpm_pkg::H_OFS_CMD}, {30'h0, o}, r);
		k = 0;
		do begin
			ahb(1'b0, {24'h0, fpm_pkg::H_OFS_STAT}, 32'h0, r);
			k++;
		end while (r[0] !== 1'b0 && k < 50);
		q = r[15:8];
	endtask

	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		logic [7:0] q;
		op(fpm_pkg::OP_WRITE, a, d, q);
	endtask

	task automatic unl(input logic [7:0] c);
		wr(16'h0555, 8'hAA);
		wr(16'h0AAA, 8'h55);
		wr(16'h0555, c);
	endtask

	task automatic erase(input logic [7:0] c);
		unl(fpm_pkg::CMD_ERASE);
		unl(c);
	endtask

	task automatic dec(input logic w, input logic [7:0] p);
		@(posedge ref_clk);
		control_register_window <= w;
		static_ram_select <= 1'b0;
		peripheral_io_window <= 1'b0;
		secondary_sector_selects <= 4'h0;
		primary_sector_selects <= p;
	endtask

	task automatic pulse(input logic e);
		@(posedge ref_clk);
		array_done <= 1'b1;
		array_error <= e;
		@(posedge ref_clk);
		array_done <= 1'b0;
		array_error <= 1'b0;
		@(posedge ref_clk);
	endtask

	task automatic wait_rdy();
		int k;
		k = 0;
		do begin
			@(posedge ref_clk);
			k++;
		end while (flash_ready !== 1'b1 && k < REC + 40);
		`CHK(flash_ready, 1'b1)
	endtask

	initial begin
		logic [7:0] q, lp, v, md;
		logic [3:0] ls;
		int n, m;
		{hsel, hwrite, lock_load, security_in, flash_reset_pin} = '0;
		{array_done, array_error, static_ram_select} = '0;
		{control_register_window, peripheral_io_window} = '0;
		{haddr, hwdata, htrans, mem_rdata} = '0;
		{primary_sector_selects, secondary_sector_selects} = '0;
		{lock_primary_in, lock_secondary_in} = '0;
		{error_cnt, compares, cyc, n_prog, n_erase, n_abort} = '0;
		seed = 13101;
		reset_n = 1'b0;
		repeat (2) @(posedge ref_clk);
		reset_n <= 1'b1;
		dec(1'b1, 8'h00);
		op(fpm_pkg::OP_READ, 16'h00C0, 8'h00, q);
		`CHK(q, 8'h00)
		lp = 8'($random(seed));
		lp[1:0] = 2'b10;
		ls = 4'($random(seed));
		@(posedge ref_clk);
		lock_load <= 1'b1;
		lock_primary_in <= lp;
		lock_secondary_in <= ls;
		security_in <= 1'b1;
		@(posedge ref_clk);
		lock_load <= 1'b0;
		for (int i = 0; i < 2; i++) begin
			op(fpm_pkg::OP_READ, 16'h00C0, 8'h00, q);
			`CHK(q, lp)
			op(fpm_pkg::OP_READ, 16'h00C2, 8'h00, q);
			`CHK(q, {1'b1, 3'b000, ls})
			wr(16'h00C0, ~lp);
			wr(16'h00C2, 8'hFF);
		end
		op(fpm_pkg::OP_READ, 16'h00C4, 8'h00, q);
		`CHK(q, 8'h0C)
		for (int i = 0; i < 5; i++) begin
			v = (i == 0) ? 8'h0C : 8'($random(seed));
			wr(16'h00C4, v);
			op(fpm_pkg::OP_READ, 16'h00C4, 8'h00, q);
			`CHK(q, v & fpm_pkg::MAP_USED)
		end
		wr(16'h00C4, 8'h9F);
		// Overlap sweep: at most one of sram, window and io at a time.
		for (int i = 0; i < 24; i++) begin
			v = 8'($random(seed));
			@(posedge ref_clk);
			static_ram_select <= v[0];
			control_register_window <= v[1] & ~v[0];
			peripheral_io_window <= v[2] & ~v[1] & ~v[0];
			primary_sector_selects <= 8'h01 << v[5:3];
			secondary_sector_selects <= v[7] ? 4'h1 << v[4:3] : 4'h0;
			md = 8'($random(seed));
			mem_rdata <= md;
			op(i[0] ? fpm_pkg::OP_READ : fpm_pkg::OP_FETCH, 16'h8000,
				8'h00, q);
			// A window read of an unmapped offset returns zero.
			`CHK(q, (i[0] && v[1] && !v[0]) ? 8'h00 : md)
		end
		dec(1'b1, 8'h00);
		wr(16'h00C4, 8'h1C);
		dec(1'b0, 8'h01);
		n = n_prog;
		unl(fpm_pkg::CMD_PROGRAM);
		wr(16'h0123, 8'($random(seed)));
		`CHK(n_prog, n + 1)
		wr(16'h0000, fpm_pkg::CMD_RESET);
		`CHK(flash_ready, 1'b0)
		pulse(1'b0);
		wait_rdy();
		dec(1'b0, 8'h02);
		n = n_prog;
		unl(fpm_pkg::CMD_PROGRAM);
		wr(16'h0123, 8'h00);
		`CHK(n_prog, n)
		`CHK(flash_ready, 1'b1)
		v = 8'($random(seed));
		mem_rdata <= v;
		op(fpm_pkg::OP_READ, 16'h0123, 8'h00, q);
		`CHK(q, v)
		dec(1'b0, 8'h01);
		unl(fpm_pkg::CMD_PROGRAM);
		wr(16'h0040, 8'h5A);
		pulse(1'b1);
		`CHK(error_flag_bit, 1'b1)
		unl(fpm_pkg::CMD_RESET);
		wait_rdy();
		`CHK(error_flag_bit, 1'b0)
		n = n_erase;
		m = n_abort;
		erase(fpm_pkg::CMD_SECTOR);
		`CHK(n_erase, n + 1)
		wr(16'h0000, fpm_pkg::CMD_RESET);
		`CHK(n_abort, m + 1)
		wait_rdy();
		n = n_erase;
		m = n_abort;
		erase(fpm_pkg::CMD_BULK);
		`CHK(n_erase, n + 1)
		wr(16'h0000, fpm_pkg::CMD_RESET);
		`CHK(n_abort, m)
		`CHK(flash_ready, 1'b0)
		pulse(1'b0);
		wait_rdy();
		n = n_erase;
		unl(fpm_pkg::CMD_ERASE);
		wr(16'h0555, 8'hAA);
		wr(16'h0AAA, 8'h77);
		wr(16'h0555, fpm_pkg::CMD_SECTOR);
		`CHK(n_erase, n)
		`CHK(flash_ready, 1'b1)
		m = n_abort;
		erase(fpm_pkg::CMD_SECTOR);
		@(posedge ref_clk);
		flash_reset_pin <= 1'b1;
		repeat (REC) @(posedge ref_clk);
		flash_reset_pin <= 1'b0;
		`CHK(n_abort, m + 1)
		wait_rdy();
		close_out();
	end
endmodule // fpm_tb
